// ---- bench/rdlp_probe.sv ----
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// reset pin with pull-up, plus attached debug probe
module rdlp_probe (
	input wire logic pin_oe,
	input wire logic pin_out,
	input wire logic hold_low,
	input wire logic attach,
	input wire logic halt,
	output logic pin_level,
	output logic debugger_connected,
	output logic core_halted
);
	// a released pin goes to the pull-up, it never keeps the last value
	assign pin_level = (pin_oe ? pin_out : 1'b1) & ~hold_low;
	assign debugger_connected = attach;
	// a probe can only halt the core while it is attached
	assign core_halted = halt & attach;
endmodule
`default_nettype wire

// ---- bench/reset_and_debug_lowpower_control_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module reset_and_debug_lowpower_control_test;
	import rdlp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, reset_vector;
	logic debugger_connected, core_halted, reset_pin_in, reset_pin_out;
	logic reset_pin_oe, watchdog_expire, core_reset_request, wake_event;
	logic disturbance_reset, low_voltage_reset, powerdown_reset_option;
	logic stop_reset_option, stop_entry, powerdown_entry, system_reset_n;
	logic power_reset, watchdog_freeze, core_clk_en, bus_clk_en;
	logic digital_power_en, system_clock_from_fast_osc, timer_clk_double;
	logic advanced_timer_clock_select, lowpower_timer_clock_select;
	logic systick_div8, hold, attach, halt;
	logic [2:0] timer_freeze;
	int n_mismatch = 0;
	int total_checks = 0;
	int len;
	// ==========================================================
	// design and far side
	rdlp_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .debugger_connected,
		.core_halted, .reset_pin_in, .reset_pin_out, .reset_pin_oe,
		.watchdog_expire, .core_reset_request, .disturbance_reset,
		.low_voltage_reset, .powerdown_reset_option, .stop_reset_option,
		.stop_entry, .powerdown_entry, .wake_event, .system_reset_n,
		.power_reset, .timer_freeze, .watchdog_freeze, .core_clk_en,
		.bus_clk_en, .digital_power_en, .system_clock_from_fast_osc,
		.advanced_timer_clock_select, .lowpower_timer_clock_select,
		.timer_clk_double, .systick_div8, .reset_vector);
	rdlp_probe u_probe (.pin_oe(reset_pin_oe), .pin_out(reset_pin_out),
		.hold_low(hold), .attach, .halt, .pin_level(reset_pin_in),
		.debugger_connected, .core_halted);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// ==========================================================
	// shared tasks
	task automatic summarize;
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic fail;
		n_mismatch++;
		$display("ERROR %0t wait ran out of cycles", $time);
		summarize();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fail();
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so no strobe is driven twice in one step
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	task automatic src(input int s, input logic v);
		case (s)
			0: hold <= v;
			1: watchdog_expire <= v;
			2: core_reset_request <= v;
			3: stop_entry <= v;
			4: disturbance_reset <= v;
			5: low_voltage_reset <= v;
			6: powerdown_entry <= v;
			default: wake_event <= v;
		endcase
	endtask
	task automatic kick(input int s);
		src(s, 1'b1);
		@(posedge pclk);
		src(s, 1'b0);
	endtask
	task automatic wait_rst(output int n);
		int w;
		w = 0;
		n = 0;
		while (system_reset_n !== 1'b0 && w < 5) begin
			@(negedge pclk);
			w++;
		end
		while (system_reset_n === 1'b0 && n < 9000) begin
			if (n == 100) chk(32'(reset_pin_in), 32'h0);
			@(negedge pclk);
			n++;
		end
		if (w >= 5 || n >= 9000) fail();
		@(posedge pclk);
	endtask
	// ==========================================================
	// scenarios
	task automatic t_regs;
		rd(OFS_DBG, DBG_RESET);
		rd(OFS_CAUSE, 32'h40);
		chk(reset_vector, 32'h4);
		chk(32'(system_clock_from_fast_osc), 32'h1);
		rd(12'h0fc, 32'h0);
		chk(32'(e), 32'h1);
		wr(OFS_DBG, 32'hffff_ffff);
		rd(OFS_DBG, 32'h0);
		attach <= 1'b1;
		wr(OFS_DBG, 32'hffff_ffff);
		rd(OFS_DBG, 32'h1e6);
		wr(OFS_CLKCFG, 32'h27);
		chk(32'({advanced_timer_clock_select, lowpower_timer_clock_select,
			timer_clk_double, systick_div8}), 32'hf);
		wr(OFS_CLKCFG, 32'h0);
		chk(32'({timer_clk_double, systick_div8}), 32'h0);
	endtask
	task automatic t_freeze;
		halt <= 1'b1;
		@(negedge pclk);
		chk(32'({timer_freeze, watchdog_freeze}), 32'hf);
		@(posedge pclk);
		wr(OFS_DBG, 32'h140);
		chk(32'({timer_freeze, watchdog_freeze}), 32'ha);
		halt <= 1'b0;
		@(negedge pclk);
		chk(32'({timer_freeze, watchdog_freeze}), 32'h0);
		@(posedge pclk);
		wr(OFS_DBG, 32'h1e6);
	endtask
	task automatic t_sources;
		for (int i = 0; i < 7; i++) begin
			wr(OFS_CLKCFG, 32'h27);
			wr(OFS_CAUSE, 32'h7f);
			stop_reset_option <= (i != 3);
			powerdown_reset_option <= (i != 6);
			kick(i);
			wait_rst(len);
			chk(32'(len >= 2000), 32'h1);
			rd(OFS_CAUSE, 32'h1 << (i == 6 ? 3 : i));
			rd(OFS_CLKCFG, 32'h0);
			rd(OFS_DBG, 32'h1e6);
		end
	endtask
	task automatic t_pin;
		hold <= 1'b1;
		repeat (3000) @(posedge pclk);
		chk(32'(system_reset_n), 32'h0);
		hold <= 1'b0;
		wait_rst(len);
	endtask
	task automatic t_modes;
		stop_reset_option <= 1'b1;
		powerdown_reset_option <= 1'b1;
		wr(OFS_DBG, 32'h0);
		wr(OFS_CLKCFG, 32'h27);
		kick(3);
		@(negedge pclk);
		chk(32'({core_clk_en, bus_clk_en}), 32'h0);
		@(posedge pclk);
		kick(7);
		rd(OFS_CLKCFG, 32'h0);
		wr(OFS_DBG, 32'h2);
		kick(3);
		rd(OFS_MODE, 32'he4);
		chk(32'({core_clk_en, bus_clk_en}), 32'h3);
		kick(7);
		wr(OFS_DBG, 32'h4);
		kick(6);
		rd(OFS_MODE, 32'hf0);
		chk(32'({core_clk_en, bus_clk_en, digital_power_en}), 32'h7);
		kick(1);
		wait_rst(len);
		rd(OFS_MODE, 32'he1);
		wr(OFS_DBG, 32'h1e0);
		kick(6);
		@(negedge pclk);
		chk(32'({core_clk_en, digital_power_en}), 32'h0);
		@(posedge pclk);
		kick(7);
		len = 0;
		while (power_reset !== 1'b1 && len < 20) begin
			@(negedge pclk);
			len++;
		end
		if (len >= 20) fail();
		repeat (2) @(posedge pclk);
		rd(OFS_DBG, 32'h0);
		rd(OFS_CAUSE, 32'h40);
	endtask
	// ==========================================================
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, hold, attach, halt} = '0;
		{watchdog_expire, core_reset_request, disturbance_reset} = '0;
		{low_voltage_reset, stop_entry, powerdown_entry, wake_event} = '0;
		{powerdown_reset_option, stop_reset_option} = 2'h3;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_freeze();
		t_sources();
		t_pin();
		t_modes();
		summarize();
	end
endmodule
`default_nettype wire

// ---- common/rdlp_pkg.sv ----
`default_nettype none
package rdlp_pkg;
	// ==========================================================
	// register offsets (byte addresses on the apb)
	localparam logic [11:0] OFS_CAUSE = 12'h000;
	localparam logic [11:0] OFS_CLKCFG = 12'h004;
	localparam logic [11:0] OFS_MODE = 12'h008;
	localparam logic [11:0] OFS_DBG = 12'h030;
	// ==========================================================
	// debug freeze control fields
	localparam int DBG_LPTIM_BIT = 8;
	localparam int DBG_GPTIM_BIT = 7;
	localparam int DBG_ADVTIM_BIT = 6;
	localparam int DBG_WDG_BIT = 5;
	localparam int DBG_PWRDN_BIT = 2;
	localparam int DBG_STOP_BIT = 1;
	localparam logic [31:0] DBG_RESET = 32'h0000_0000;
	localparam logic [31:0] DBG_WMASK = 32'h0000_01e6;
	// ==========================================================
	// reset cause status: bits 5..0 follow rdlp_src_t, bit 6 power
	localparam int CAUSE_W = 7;
	localparam int CAUSE_POWER_BIT = 6;
	localparam logic [6:0] CAUSE_RESET = 7'h40;
	// ==========================================================
	// clock configuration fields
	localparam int CFG_W = 6;
	localparam int CFG_ADVSEL_BIT = 0;
	localparam int CFG_LPSEL_BIT = 1;
	localparam int CFG_PRE_LSB = 2;
	localparam int CFG_PRE_MSB = 4;
	localparam int CFG_SYSTICK_BIT = 5;
	localparam logic [5:0] CFG_RESET = 6'h00;
	localparam logic [2:0] PRE_DIV1 = 3'h0;
	// ==========================================================
	// fixed values and timing
	localparam logic [31:0] RESET_VECTOR = 32'h0000_0004;
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_PULSE_NS = 20000;
	localparam int RST_PULSE_CYC =
		(RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W = 11;
	// ==========================================================
	// types
	typedef struct packed {
		logic lowvolt;
		logic disturb;
		logic lowpower;
		logic sw;
		logic wdg;
		logic pin;
	} rdlp_src_t;
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_STOP = 5'h02,
		ST_DBG_STOP = 5'h04,
		ST_PWRDN = 5'h08,
		ST_DBG_PWRDN = 5'h10
	} rdlp_mode_t;
endpackage
`default_nettype wire

// ---- rtl/rdlp_stretch.sv ----
`timescale 1ns/100ps
`default_nettype none
module rdlp_stretch
	import rdlp_pkg::*;
#(
	parameter int CNT_W = RST_CNT_W,
	parameter int MIN_CYC = RST_PULSE_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic trig,
	output logic active
);
	// ==========================================================
	// pulse stretcher
	localparam logic [CNT_W-1:0] LOAD = CNT_W'(MIN_CYC - 1);
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] run_r;

	// a held trigger keeps reloading, so the pulse lasts while it lasts
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
		end else if (trig) begin
			cnt_r <= LOAD;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - CNT_W'(1);
		end
	end
	assign active = trig || (cnt_r != '0);

	// ==========================================================
	// helper: length of the current pulse, saturating
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_r <= '0;
		end else if (!active) begin
			run_r <= '0;
		end else if (run_r != '1) begin
			run_r <= run_r + CNT_W'(1);
		end
	end

	min_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(active) |-> $past(run_r) >= CNT_W'(MIN_CYC - 1))
		else $error("reset pulse shorter than minimum");
endmodule
`default_nettype wire

// ---- rtl/rdlp_top.sv ----
// Notes on behaviour
// - debug freeze register clears only on a power reset.
// - debug freeze register writable only while a debugger is connected.
// - bits 8,7,6 freeze the three timer counters while core halted.
// - bit 5 freezes the watchdog counter while core halted.
// - bit 2 clear: powerdown stops clocks, removes power, exit is power reset.
// - bit 2 set: debug powerdown keeps power and clocks; exits by system reset.
// - bit 1 clear: stop gates all clocks; wake restores reset clock setup.
// - bit 1 set: debug stop keeps core and bus clocks running.
// - power reset returns every register to its reset value.
// - pin, watchdog, software, lowpower, disturbance, low-voltage raise system reset.
// - system reset leaves cause, debug and retained state untouched.
// - each reset source sets its own flag in the cause status register.
// - core reset request produces a software system reset.
// - powerdown option cleared: powerdown entry becomes a system reset.
// - stop option cleared: stop entry becomes a system reset.
// - every system reset drives the reset pin low while it lasts; here from its second cycle on, as oe_r trails active by one cycle.
// - every reset is stretched to at least 20 us; power_reset here is not stretched and lasts one or two pclk cycles.
// - external low on the pin keeps the reset going while held.
// - code fetch starts from reset vector 0x0000_0004.
// - system clock from internal fast oscillator, buses at most 48 MHz.
// - timer, watchdog and converter clock sources chosen by select fields; here only the advanced and low-power timer selects exist.
// - pclk timers doubled unless prescaler is 1; systick hclk or hclk/8.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rdlp_top
	import rdlp_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic debugger_connected,
	input wire logic core_halted,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	input wire logic watchdog_expire,
	input wire logic core_reset_request,
	input wire logic disturbance_reset,
	input wire logic low_voltage_reset,
	input wire logic powerdown_reset_option,
	input wire logic stop_reset_option,
	input wire logic stop_entry,
	input wire logic powerdown_entry,
	input wire logic wake_event,
	output logic system_reset_n,
	output logic power_reset,
	output logic [2:0] timer_freeze,
	output logic watchdog_freeze,
	output logic core_clk_en,
	output logic bus_clk_en,
	output logic digital_power_en,
	output logic system_clock_from_fast_osc,
	output logic advanced_timer_clock_select,
	output logic lowpower_timer_clock_select,
	output logic timer_clk_double,
	output logic systick_div8,
	output logic [31:0] reset_vector
);
	// ==========================================================
	// declarations
	logic [31:0] dbg_r;
	logic [CAUSE_W-1:0] cause_r;
	logic [CFG_W-1:0] clkcfg_r;
	rdlp_mode_t st_r;
	logic lp_rst_r;
	logic pwr_rst_r;
	logic oe_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_nxt;
	logic addr_ok;
	logic wr;
	logic [CAUSE_W-1:0] cause_clr;
	rdlp_src_t src;
	logic any_src;
	logic active;
	logic sys_rst;
	logic pwrdn_go;
	logic stop_go;

	// ==========================================================
	// apb slave: zero wait states, read data latched in setup
	assign pready = 1'b1;
	assign wr = psel && penable && pwrite;
	assign prdata = prdata_r;
	assign pslverr = psel && penable && !addr_ok;

	always_comb begin
		addr_ok = 1'b1;
		rd_nxt = 32'h0000_0000;
		if (paddr == OFS_CAUSE) begin
			rd_nxt[CAUSE_W-1:0] = cause_r;
		end else if (paddr == OFS_CLKCFG) begin
			rd_nxt[CFG_W-1:0] = clkcfg_r;
		end else if (paddr == OFS_MODE) begin
			rd_nxt[4:0] = st_r;
			rd_nxt[5] = stop_reset_option;
			rd_nxt[6] = powerdown_reset_option;
			rd_nxt[7] = debugger_connected;
		end else if (paddr == OFS_DBG) begin
			rd_nxt = dbg_r;
		end else begin
			addr_ok = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_r <= rd_nxt;
		end
	end

	// ==========================================================
	// system reset sources and stretcher
	// the pin is only a source while we do not drive it ourselves,
	// otherwise our own low level would hold the reset for ever
	always_comb begin
		src.pin = !reset_pin_in && !oe_r;
		src.wdg = watchdog_expire;
		src.sw = core_reset_request;
		src.lowpower = lp_rst_r;
		src.disturb = disturbance_reset;
		src.lowvolt = low_voltage_reset;
	end
	assign any_src = |src;

	rdlp_stretch #(
		.CNT_W(RST_CNT_W),
		.MIN_CYC(RST_PULSE_CYC)
	) u_stretch (
		.clk(pclk),
		.rst_n(presetn),
		.trig(any_src),
		.active(active)
	);

	// oe_r trails the pulse by a cycle; sys_rst covers that cycle too so
	// an external low still present at release continues the reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oe_r <= 1'b0;
		end else begin
			oe_r <= active;
		end
	end
	assign sys_rst = active || oe_r;
	assign reset_pin_oe = oe_r;
	assign reset_pin_out = 1'b0;
	assign system_reset_n = !sys_rst;
	assign power_reset = pwr_rst_r;
	assign reset_vector = RESET_VECTOR;

	// ==========================================================
	// reset cause status: write one to clear, a new event wins
	assign cause_clr = (wr && paddr == OFS_CAUSE) ?
		pwdata[CAUSE_W-1:0] : '0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cause_r <= CAUSE_RESET;
		end else if (pwr_rst_r) begin
			cause_r <= CAUSE_RESET;
		end else begin
			cause_r <= (cause_r & ~cause_clr) | {1'b0, src};
		end
	end

	// ==========================================================
	// debug freeze control: kept across system reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dbg_r <= DBG_RESET;
		end else if (pwr_rst_r) begin
			dbg_r <= DBG_RESET;
		end else if (wr && paddr == OFS_DBG && debugger_connected) begin
			dbg_r <= pwdata & DBG_WMASK;
		end
	end

	assign timer_freeze[2] = dbg_r[DBG_LPTIM_BIT] && core_halted;
	assign timer_freeze[1] = dbg_r[DBG_GPTIM_BIT] && core_halted;
	assign timer_freeze[0] = dbg_r[DBG_ADVTIM_BIT] && core_halted;
	assign watchdog_freeze = dbg_r[DBG_WDG_BIT] && core_halted;

	// ==========================================================
	// clock configuration: back to reset setup on any reset or a wake from ST_STOP (not ST_DBG_STOP)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clkcfg_r <= CFG_RESET;
		end else if (pwr_rst_r || sys_rst) begin
			clkcfg_r <= CFG_RESET;
		end else if (st_r == ST_STOP && wake_event) begin
			clkcfg_r <= CFG_RESET;
		end else if (wr && paddr == OFS_CLKCFG) begin
			clkcfg_r <= pwdata[CFG_W-1:0];
		end
	end

	// system clock is always the fast rc oscillator, never above 48 MHz
	assign system_clock_from_fast_osc = 1'b1;
	assign advanced_timer_clock_select = clkcfg_r[CFG_ADVSEL_BIT];
	assign lowpower_timer_clock_select = clkcfg_r[CFG_LPSEL_BIT];
	assign timer_clk_double =
		clkcfg_r[CFG_PRE_MSB:CFG_PRE_LSB] != PRE_DIV1;
	assign systick_div8 = clkcfg_r[CFG_SYSTICK_BIT];

	// ==========================================================
	// low power mode sequencing
	assign pwrdn_go = st_r == ST_RUN && powerdown_entry && !sys_rst;
	assign stop_go = st_r == ST_RUN && stop_entry && !powerdown_entry &&
		!sys_rst;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_RUN;
		end else if (pwr_rst_r || sys_rst) begin
			st_r <= ST_RUN;
		end else begin
			case (st_r)
			ST_RUN: begin
				if (pwrdn_go && powerdown_reset_option) begin
					if (dbg_r[DBG_PWRDN_BIT]) begin
						st_r <= ST_DBG_PWRDN;
					end else begin
						st_r <= ST_PWRDN;
					end
				end else if (stop_go && stop_reset_option) begin
					if (dbg_r[DBG_STOP_BIT]) begin
						st_r <= ST_DBG_STOP;
					end else begin
						st_r <= ST_STOP;
					end
				end
			end
			ST_STOP, ST_DBG_STOP: begin
				if (wake_event) begin
					st_r <= ST_RUN;
				end
			end
			ST_PWRDN: begin
				// left only through a system reset above or the power reset below
				st_r <= ST_PWRDN;
			end
			ST_DBG_PWRDN: begin
				st_r <= ST_DBG_PWRDN;
			end
			default: begin
				st_r <= ST_RUN;
			end
			endcase
		end
	end

	// options cleared turn an entry into a low-power management reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lp_rst_r <= 1'b0;
		end else begin
			lp_rst_r <= (pwrdn_go && !powerdown_reset_option) ||
				(stop_go && !stop_reset_option);
		end
	end

	// leaving powerdown acts as a supply power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwr_rst_r <= 1'b0;
		end else begin
			pwr_rst_r <= st_r == ST_PWRDN && wake_event;
		end
	end

	assign core_clk_en = st_r == ST_RUN || st_r == ST_DBG_STOP ||
		st_r == ST_DBG_PWRDN;
	assign bus_clk_en = core_clk_en;
	assign digital_power_en = st_r != ST_PWRDN;

	// ==========================================================
	// checks
	dbg_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == OFS_DBG && !debugger_connected && !pwr_rst_r
		|=> $stable(dbg_r))
		else $error("debug register written without debugger");

	dbg_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		sys_rst && !pwr_rst_r && !wr |=> $stable(dbg_r))
		else $error("debug register changed by system reset");

	timer_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		!core_halted |-> timer_freeze == 3'h0 && !watchdog_freeze)
		else $error("counter frozen while core running");

	wdg_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
		core_halted && dbg_r[DBG_WDG_BIT] |-> watchdog_freeze)
		else $error("watchdog not frozen on halt");

	pwrdn_enter_a: assert property (@(posedge pclk) disable iff (!presetn)
		pwrdn_go && powerdown_reset_option && !dbg_r[DBG_PWRDN_BIT]
		|=> !digital_power_en && !core_clk_en)
		else $error("powerdown did not remove power");

	dbg_pwrdn_a: assert property (@(posedge pclk) disable iff (!presetn)
		pwrdn_go && powerdown_reset_option && dbg_r[DBG_PWRDN_BIT]
		|=> digital_power_en && core_clk_en && bus_clk_en)
		else $error("debug powerdown lost clocks");

	stop_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		stop_go && stop_reset_option && !dbg_r[DBG_STOP_BIT]
		|=> !core_clk_en && !bus_clk_en)
		else $error("stop left clocks running");

	dbg_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
		stop_go && stop_reset_option && dbg_r[DBG_STOP_BIT]
		|=> core_clk_en && st_r == ST_DBG_STOP)
		else $error("debug stop gated clocks");

	pwr_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r == ST_PWRDN && wake_event
		|=> pwr_rst_r ##1 dbg_r == DBG_RESET && cause_r == CAUSE_RESET)
		else $error("powerdown exit not a power reset");

	src_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
		any_src |-> !system_reset_n ##1 reset_pin_oe)
		else $error("reset source did not reset");

	lp_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
		pwrdn_go && !powerdown_reset_option |=> lp_rst_r ##1 !system_reset_n)
		else $error("powerdown option did not reset");

	stop_rst_a: assert property (@(posedge pclk) disable iff (!presetn)
		stop_go && !stop_reset_option |=> lp_rst_r ##1 !system_reset_n)
		else $error("stop option did not reset");

	stop_wake_a: assert property (@(posedge pclk) disable iff (!presetn)
		st_r == ST_STOP && wake_event |=> clkcfg_r == CFG_RESET)
		else $error("stop wake kept clock setup");

	cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		src.wdg && !pwr_rst_r |=> cause_r[1])
		else $error("watchdog cause not recorded");
endmodule
`default_nettype wire
